// [hw/gear_top.sv]
// Purpose: per-axis electronic gearing with ramped engagement
// Assumes: commanded positions and vector distance come from this clock
// Notes:   bus is stalled while an update walks the axes
`timescale 1ns/1ps

// Notes on behaviour
// - eight slave axes geared at once, each with its own master.
// - signed ratio up to 127.9999 in steps of 0.0001.
// - each axis has its own ratio, changeable during motion.
// - slave change is master change times signed ratio, both ways.
// - gantry select 1 sets gantry mode, 0 standard mode.
// - a zero ratio turns gearing off in either mode.
// - limit or stop ends gearing in standard mode only.
// - encoder master follows the measured position of the master.
// - commanded master follows the master's commanded trajectory.
// - vector master follows coordinated path distance.
// - an independent move is added on top of the geared position.
// - ratio changes ramp in over a span of master travel.
// - ramp lag is accumulated in a readable operand.
// - ramp span is per axis, in master distance.
// - lag is instant-engagement travel minus actual travel.
module gear_top #(
   parameter int SERVO_CYCLES = gear_pkg::SERVO_CYCLES,
   parameter int MOVE_STEP    = gear_pkg::MOVE_STEP
) (
   // clock and reset
   input  wire logic                                       clk_sys,
   input  wire logic                                       nrst,
   // avalon-mm slave, word addressed
   input  wire logic [5:0]                                 address,
   input  wire logic                                       read,
   input  wire logic                                       write,
   input  wire logic [31:0]                                writedata,
   output logic      [31:0]                                readdata,
   output logic                                            waitrequest,
   // master sources
   input  wire logic [gear_pkg::NUM_AXES-1:0][31:0]        enc_pos,
   input  wire logic [gear_pkg::NUM_AXES-1:0][31:0]        cmd_pos,
   input  wire logic [31:0]                                vector_distance,
   input  wire logic [gear_pkg::NUM_AXES-1:0]              limit_switch,
   // slave motor command
   output logic      [gear_pkg::NUM_AXES-1:0][31:0]        slave_cmd_pos,
   output logic      [gear_pkg::NUM_AXES-1:0]              gear_active
);
   localparam int N  = gear_pkg::NUM_AXES;
   localparam int RW = gear_pkg::RATIO_W;
   localparam int AW = gear_pkg::ACC_W;
   localparam int SW = N * 32 + N;

   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   logic [SW-1:0]       pin_sync;
   logic [N-1:0][31:0]  enc_sync;
   logic [N-1:0]        lim_sync;

   gear_sync #(.W(SW)) u_sync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .din     ({limit_switch, enc_pos}),
      .dout    (pin_sync)
   );
   assign enc_sync = pin_sync[N*32-1:0];
   assign lim_sync = pin_sync[SW-1:N*32];

   // -------------------------------------------------------------
   // per-axis state
   // -------------------------------------------------------------
   logic        [4:0]     src_sel    [N];
   logic signed [RW-1:0]  ratio_new  [N];
   logic signed [RW-1:0]  ratio_old  [N];
   logic signed [RW-1:0]  ratio_eff  [N];
   logic                  gantry     [N];
   logic        [31:0]    span       [N];
   logic        [31:0]    trav       [N];
   logic signed [AW-1:0]  resid      [N];
   logic signed [AW-1:0]  lag_acc    [N];
   logic signed [31:0]    move_rem   [N];
   logic signed [31:0]    jog        [N];

   // master history and deltas
   logic [N-1:0][31:0]    prev_act;
   logic [N-1:0][31:0]    prev_cmd;
   logic [31:0]           prev_vec;
   logic [N-1:0][31:0]    d_act;
   logic [N-1:0][31:0]    d_cmd;
   logic [31:0]           d_vec;

   // sequencer
   gear_pkg::seq_state_t  state;
   logic [31:0]           tick_cnt;
   logic                  tick_pend;
   logic [2:0]            idx;
   logic                  grant;
   logic                  bus_wr;
   logic                  bus_rd_ok;

   gear_calc_if calc ();

   gear_engine u_engine (
      .c (calc)
   );

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // pick the delta of the master an axis follows
   function automatic logic signed [31:0] pick_delta(input logic [4:0] sel);
      logic [2:0] m;
      m = sel[gear_pkg::SRC_AXIS_LSB +: 3];
      unique case (gear_pkg::src_kind_t'(sel[gear_pkg::SRC_KIND_LSB +: 2]))
         gear_pkg::SRC_ACTUAL:    return d_act[m];
         gear_pkg::SRC_COMMANDED: return d_cmd[m];
         gear_pkg::SRC_VECTOR:    return d_vec;
         default:                 return 32'h0000_0000;
      endcase
   endfunction : pick_delta

   // bounded step of the superimposed move
   function automatic logic signed [31:0] move_step(input logic signed [31:0] rem);
      if (rem > MOVE_STEP)
         return 32'(MOVE_STEP);
      else if (rem < -MOVE_STEP)
         return -32'(MOVE_STEP);
      else
         return rem;
   endfunction : move_step

   // -------------------------------------------------------------
   // servo tick
   // -------------------------------------------------------------
   // the tick only raises a request; the walk waits for an idle bus
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tick_cnt <= 32'h0000_0000;
      end else if (tick_cnt == 32'(SERVO_CYCLES - 1)) begin
         tick_cnt <= 32'h0000_0000;
      end else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
   end

   // pending request: a new tick wins over the clear at walk start
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tick_pend <= 1'b0;
      end else if (tick_cnt == 32'(SERVO_CYCLES - 1)) begin
         tick_pend <= 1'b1;
      end else if (state == gear_pkg::SEQ_IDLE && waitrequest && !grant) begin
         tick_pend <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // update sequencer
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         state <= gear_pkg::SEQ_IDLE;
         idx   <= 3'h0;
      end else begin
         unique case (state)
            gear_pkg::SEQ_IDLE: begin
               if (tick_pend && waitrequest && !grant) begin
                  state <= gear_pkg::SEQ_SNAP;
               end
            end
            gear_pkg::SEQ_SNAP: begin
               state <= gear_pkg::SEQ_WALK;
               idx   <= 3'h0;
            end
            gear_pkg::SEQ_WALK: begin
               idx <= idx + 3'h1;
               if (idx == 3'(N - 1)) begin
                  state <= gear_pkg::SEQ_IDLE;
               end
            end
            default: state <= gear_pkg::SEQ_IDLE;
         endcase
      end
   end

   // snapshot of every master source, differenced against the last one
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prev_act <= '0;
         prev_cmd <= '0;
         prev_vec <= 32'h0000_0000;
         d_act    <= '0;
         d_cmd    <= '0;
         d_vec    <= 32'h0000_0000;
      end else if (state == gear_pkg::SEQ_SNAP) begin
         for (int m = 0; m < N; m++) begin
            d_act[m] <= enc_sync[m] - prev_act[m];
            d_cmd[m] <= cmd_pos[m] - prev_cmd[m];
         end
         d_vec    <= vector_distance - prev_vec;
         prev_act <= enc_sync;
         prev_cmd <= cmd_pos;
         prev_vec <= vector_distance;
      end
   end

   // present the walking axis to the shared engine
   always_comb begin
      calc.delta     = pick_delta(src_sel[idx]);
      calc.ratio_old = ratio_old[idx];
      calc.ratio_new = ratio_new[idx];
      calc.trav      = trav[idx];
      calc.span      = span[idx];
      calc.resid     = resid[idx];
   end

   // -------------------------------------------------------------
   // avalon handshake
   // -------------------------------------------------------------
   // one wait cycle, more while an update walk owns the axis state
   assign grant     = (read || write) && waitrequest && state == gear_pkg::SEQ_IDLE
                      && !tick_pend;
   assign bus_wr    = write && !waitrequest;
   assign bus_rd_ok = read && grant;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !grant;
      end
   end

   // read data is latched with the grant and stands through the answer
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         readdata <= 32'h0000_0000;
      end else if (bus_rd_ok) begin
         unique case (address[2:0])
            gear_pkg::REG_SOURCE: readdata <= {27'h000_0000, src_sel[address[5:3]]};
            gear_pkg::REG_RATIO:  readdata <= 32'(ratio_new[address[5:3]]);
            gear_pkg::REG_GANTRY: readdata <= {31'h0000_0000, gantry[address[5:3]]};
            gear_pkg::REG_SPAN:   readdata <= span[address[5:3]];
            gear_pkg::REG_CTRL:   readdata <= {30'h0000_0000,
                                     gear_active[address[5:3]] &&
                                     trav[address[5:3]] < span[address[5:3]],
                                     gear_active[address[5:3]]};
            gear_pkg::REG_MOVE:   readdata <= move_rem[address[5:3]];
            gear_pkg::REG_JOG:    readdata <= jog[address[5:3]];
            gear_pkg::REG_LAG:    readdata <= 32'(lag_acc[address[5:3]] /
                                     $signed({32'h0000_0000, gear_pkg::RATIO_SCALE}));
            default:              readdata <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------
   // axis configuration written by software
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         for (int a = 0; a < N; a++) begin
            src_sel[a] <= gear_pkg::RESET_SOURCE;
            gantry[a]  <= 1'b0;
            span[a]    <= gear_pkg::RESET_SPAN;
         end
      end else if (bus_wr) begin
         unique case (address[2:0])
            gear_pkg::REG_SOURCE: src_sel[address[5:3]] <= writedata[4:0];
            gear_pkg::REG_GANTRY: gantry[address[5:3]]  <= writedata[0];
            gear_pkg::REG_SPAN:   span[address[5:3]]    <= writedata;
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------
   // gearing state: ratio writes, stops, limits and the update walk
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         for (int a = 0; a < N; a++) begin
            ratio_new[a]   <= '0;
            ratio_old[a]   <= '0;
            ratio_eff[a]   <= '0;
            trav[a]        <= 32'h0000_0000;
            resid[a]       <= '0;
            lag_acc[a]     <= '0;
            gear_active[a] <= 1'b0;
         end
      end else if (bus_wr && address[2:0] == gear_pkg::REG_RATIO) begin
         ratio_new[address[5:3]] <= gear_pkg::sat_ratio(writedata);
         trav[address[5:3]]      <= 32'h0000_0000;
         // a change mid-motion ramps from the ratio now in force
         ratio_old[address[5:3]] <= gear_active[address[5:3]] ?
                                    ratio_eff[address[5:3]] : '0;
         if (writedata == 32'h0000_0000) begin
            gear_active[address[5:3]] <= 1'b0;
            ratio_eff[address[5:3]]   <= '0;
         end else begin
            gear_active[address[5:3]] <= 1'b1;
            if (!gear_active[address[5:3]]) begin
               resid[address[5:3]]   <= '0;
               lag_acc[address[5:3]] <= '0;
               ratio_eff[address[5:3]] <= '0;
            end
         end
      end else if (bus_wr && address[2:0] == gear_pkg::REG_CTRL) begin
         if (writedata[gear_pkg::CTRL_STOP_BIT] && !gantry[address[5:3]]) begin
            gear_active[address[5:3]] <= 1'b0;
         end
         if (writedata[gear_pkg::CTRL_CLEAR_BIT]) begin
            lag_acc[address[5:3]] <= '0;
         end
      end else if (state == gear_pkg::SEQ_WALK) begin
         if (lim_sync[idx] && !gantry[idx]) begin
            gear_active[idx] <= 1'b0;
         end else if (gear_active[idx]) begin
            ratio_eff[idx] <= calc.eff;
            trav[idx]      <= calc.trav_next;
            resid[idx]     <= calc.resid_next;
            lag_acc[idx]   <= lag_acc[idx] + calc.lag_inc;
         end
      end
   end

   // -------------------------------------------------------------
   // superimposed moves
   // -------------------------------------------------------------
   // a relative move adds to what remains; a stop drops both moves
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         for (int a = 0; a < N; a++) begin
            move_rem[a] <= 32'h0000_0000;
            jog[a]      <= 32'h0000_0000;
         end
      end else if (bus_wr && address[2:0] == gear_pkg::REG_MOVE) begin
         move_rem[address[5:3]] <= move_rem[address[5:3]] + writedata;
      end else if (bus_wr && address[2:0] == gear_pkg::REG_JOG) begin
         jog[address[5:3]] <= writedata;
      end else if (bus_wr && address[2:0] == gear_pkg::REG_CTRL
                   && writedata[gear_pkg::CTRL_STOP_BIT]) begin
         move_rem[address[5:3]] <= 32'h0000_0000;
         jog[address[5:3]]      <= 32'h0000_0000;
      end else if (state == gear_pkg::SEQ_WALK) begin
         move_rem[idx] <= move_rem[idx] - move_step(move_rem[idx]);
      end
   end

   // -------------------------------------------------------------
   // slave command position
   // -------------------------------------------------------------
   // geared step plus the independent profile, one axis per clock
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         slave_cmd_pos <= '0;
      end else if (state == gear_pkg::SEQ_WALK) begin
         if (gear_active[idx] && !(lim_sync[idx] && !gantry[idx])) begin
            slave_cmd_pos[idx] <= slave_cmd_pos[idx] + calc.step
                                  + move_step(move_rem[idx]) + jog[idx];
         end else begin
            slave_cmd_pos[idx] <= slave_cmd_pos[idx]
                                  + move_step(move_rem[idx]) + jog[idx];
         end
      end
   end
endmodule : gear_top

// [hw/gear_pkg.sv]
// Purpose: shared constants and types of the electronic gearing engine
// Assumes: 10 MHz system clock, fixed servo update period
// Notes:   ratios are signed integers in units of 0.0001
package gear_pkg;
   // -------------------------------------------------------------
   // sizes and number formats
   // -------------------------------------------------------------
   localparam int          NUM_AXES    = 8;
   localparam int          POS_W       = 32;
   localparam int          RATIO_W     = 22;
   localparam int          ACC_W       = 64;
   localparam logic [31:0] RATIO_SCALE = 32'h0000_2710;  // 10000 steps per unit
   localparam logic [31:0] RATIO_MAX   = 32'h0013_87FF;  // 127.9999 in 0.0001 units

   // -------------------------------------------------------------
   // register map: word address = {axis, register}
   // -------------------------------------------------------------
   localparam logic [2:0] REG_SOURCE = 3'h0;
   localparam logic [2:0] REG_RATIO  = 3'h1;
   localparam logic [2:0] REG_GANTRY = 3'h2;
   localparam logic [2:0] REG_SPAN   = 3'h3;
   localparam logic [2:0] REG_CTRL   = 3'h4;
   localparam logic [2:0] REG_MOVE   = 3'h5;
   localparam logic [2:0] REG_JOG    = 3'h6;
   localparam logic [2:0] REG_LAG    = 3'h7;

   // field positions
   localparam int SRC_AXIS_LSB   = 0;
   localparam int SRC_KIND_LSB   = 3;
   localparam int CTRL_STOP_BIT  = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int STAT_GEAR_BIT  = 0;
   localparam int STAT_RAMP_BIT  = 1;

   // reset values
   localparam logic [4:0]  RESET_SOURCE = 5'h00;
   localparam logic [31:0] RESET_SPAN   = 32'h0000_0000;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int SERVO_PERIOD_NS = 1000000;
   localparam int SERVO_CYCLES    = SERVO_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MOVE_STEP       = 16;   // superimposed move, counts per update

   typedef enum logic [1:0] {
      SRC_ACTUAL    = 2'b00,
      SRC_COMMANDED = 2'b01,
      SRC_VECTOR    = 2'b10
   } src_kind_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_SNAP = 2'b01,
      SEQ_WALK = 2'b10
   } seq_state_t;

   // clip a written ratio to the legal signed range
   function automatic logic signed [RATIO_W-1:0] sat_ratio(input logic signed [31:0] v);
      if (v > $signed(RATIO_MAX))
         return RATIO_W'(RATIO_MAX);
      else if (v < -$signed(RATIO_MAX))
         return RATIO_W'(-$signed(RATIO_MAX));
      else
         return v[RATIO_W-1:0];
   endfunction : sat_ratio
endpackage : gear_pkg

// [hw/gear_calc_if.sv]
// Purpose: carries one axis worth of gearing arithmetic
// Assumes: driven by the sequencer, answered combinationally
// Notes:   one axis is presented per clock during an update walk
`timescale 1ns/1ps
interface gear_calc_if;
   logic signed [31:0]                     delta;
   logic signed [gear_pkg::RATIO_W-1:0]   ratio_old;
   logic signed [gear_pkg::RATIO_W-1:0]   ratio_new;
   logic        [31:0]                     trav;
   logic        [31:0]                     span;
   logic signed [gear_pkg::ACC_W-1:0]     resid;
   logic signed [31:0]                     step;
   logic signed [gear_pkg::ACC_W-1:0]     resid_next;
   logic signed [gear_pkg::RATIO_W-1:0]   eff;
   logic        [31:0]                     trav_next;
   logic signed [gear_pkg::ACC_W-1:0]     lag_inc;

   modport seq (output delta, ratio_old, ratio_new, trav, span, resid,
                input  step, resid_next, eff, trav_next, lag_inc);
   modport engine (input delta, ratio_old, ratio_new, trav, span, resid,
                   output step, resid_next, eff, trav_next, lag_inc);
endinterface : gear_calc_if

// [hw/gear_sync.sv]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: each bit is an independent level
// Notes:   multi-bit words may tear; consumers take differences only
`timescale 1ns/1ps
module gear_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   // data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : gear_sync

// [hw/gear_engine.sv]
// Purpose: ramped ratio and position step for one axis
// Assumes: span zero means instant engagement
// Notes:   combinational; shared by all axes in turn
`timescale 1ns/1ps
module gear_engine (
   gear_calc_if.engine c
);
   logic        [32:0]              mag;
   logic        [33:0]              sum;
   logic signed [22:0]              diff;
   logic signed [63:0]              ramp;
   logic signed [gear_pkg::ACC_W-1:0] act;
   logic signed [gear_pkg::ACC_W-1:0] q;

   // ratio climbs linearly with master travel, then the step is scaled
   always_comb begin
      mag = c.delta < 0 ? 33'(-$signed({c.delta[31], c.delta})) : {1'b0, c.delta};
      sum = {1'b0, c.trav} + {1'b0, mag};
      c.trav_next = (sum >= {2'b00, c.span}) ? c.span : sum[31:0];
      diff = 23'(c.ratio_new) - 23'(c.ratio_old);
      ramp = 64'(diff) * $signed({32'h0000_0000, c.trav_next});
      if (c.span == 32'h0000_0000 || c.trav_next >= c.span)
         c.eff = c.ratio_new;
      else
         c.eff = c.ratio_old + RATIO_W_CUT(ramp / $signed({32'h0000_0000, c.span}));
      act = c.resid + 64'(c.delta) * 64'(c.eff);
      q = act / $signed({32'h0000_0000, gear_pkg::RATIO_SCALE});
      c.step = q[31:0];
      c.resid_next = act - q * $signed({32'h0000_0000, gear_pkg::RATIO_SCALE});
      c.lag_inc = 64'(c.delta) * 64'(c.ratio_new) - 64'(c.delta) * 64'(c.eff);
   end

   function automatic logic signed [gear_pkg::RATIO_W-1:0] RATIO_W_CUT(input logic signed [63:0] v);
      return v[gear_pkg::RATIO_W-1:0];
   endfunction : RATIO_W_CUT
endmodule : gear_engine

// [sim/gear_top_properties.sv]
// Purpose: port-level checks of the gearing block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module gear_props (
   // clock, reset, bus
   input wire logic                  clk_sys,
   input wire logic                  nrst,
   input wire logic [5:0]            address,
   input wire logic                  read,
   input wire logic                  write,
   input wire logic [31:0]           writedata,
   input wire logic [31:0]           readdata,
   input wire logic                  waitrequest,
   // slave side
   input wire logic [7:0][31:0]      slave_cmd_pos,
   input wire logic [7:0]            gear_active
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // a ratio write answered this cycle
   logic rw;
   assign rw = write && !waitrequest && address[2:0] == gear_pkg::REG_RATIO;
   // plain helper nets, so that $past only ever looks back at a signal
   logic       rw_axis1;
   logic [2:0] slot;
   assign rw_axis1 = rw && address[5:3] == 3'h1;
   assign slot     = address[5:3];
   reset_state_a: assert property (disable iff (1'b0) !nrst |=> waitrequest && !gear_active)
      else $error("outputs busy after reset");
   answer_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("answer held too long");
   answer_cause_a: assert property (!waitrequest |-> read || write)
      else $error("answer without request");
   answer_bound_a: assert property ((read || write) && waitrequest |-> ##[1:14] !waitrequest)
      else $error("request not answered");
   zero_off_a: assert property (rw && !writedata |=> !gear_active[$past(slot)])
      else $error("zero ratio left gearing on");
   ratio_on_a: assert property (rw && writedata |=> gear_active[$past(slot)])
      else $error("ratio did not engage");
   rise_cause_a: assert property ($rose(gear_active[1]) |-> $past(rw_axis1))
      else $error("gearing rose without a write");
   walk_quiet_a: assert property (!waitrequest |-> $stable(slave_cmd_pos))
      else $error("slave moved outside a walk");
   read_hold_a: assert property ($changed(readdata) |-> read && !waitrequest)
      else $error("read data moved unasked");
   cover property (rw);
   cover property (read && !waitrequest && address[2:0] == gear_pkg::REG_LAG);
   cover property ($fell(gear_active[2]));
endmodule : gear_props
bind gear_top gear_props props (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .slave_cmd_pos(slave_cmd_pos), .gear_active(gear_active));

// [sim/axis_model.sv]
// Purpose: encoders of the master axes
// Assumes: bench asks for travel one clock at a time
// Notes:   only axis 0 turns; an idle machine keeps its counts
`timescale 1ns/1ps
module axis_model (
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   input  wire logic signed [31:0]  step,
   output logic        [7:0][31:0]  enc_pos
);
   // counts advance by the requested travel each clock
   always_ff @(posedge clk_sys) begin
      if (!nrst)
         enc_pos <= '0;
      else
         enc_pos[0] <= enc_pos[0] + step;
   end
endmodule : axis_model

// [sim/tb_top.sv]
// Purpose: self-checking bench of the gearing block
// Assumes: 20-clock servo period
// Notes:   updates are awaited with margin, master moves between them
`timescale 1ns/1ps
module tb_top;
   logic                clk_sys, nrst, read, write, waitrequest;
   logic [5:0]          address;
   logic [31:0]         writedata, readdata, vector_distance, rd, p0;
   logic [7:0][31:0]    enc_pos, cmd_pos, slave_cmd_pos;
   logic [7:0]          limit_switch, gear_active;
   logic signed [31:0]  step;
   int                  fails = 0, checked = 0;
   gear_top #(.SERVO_CYCLES(20), .MOVE_STEP(16)) uut (.clk_sys(clk_sys), .nrst(nrst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .enc_pos(enc_pos), .cmd_pos(cmd_pos),
      .vector_distance(vector_distance), .limit_switch(limit_switch),
      .slave_cmd_pos(slave_cmd_pos), .gear_active(gear_active));
   axis_model model (.clk_sys(clk_sys), .nrst(nrst), .step(step), .enc_pos(enc_pos));
   initial begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end
   // bus access held until the answer edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {read, write, address, writedata} <= {!wr, wr, a, d};
      do @(posedge clk_sys); while (waitrequest);
      rd = readdata;
      {read, write} <= 2'b00;
   endtask : bus
   task automatic chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %0d want %0d", $time, $signed(got), $signed(exp));
      end
   endtask : chk
   // four servo periods, so a change has surely been walked
   task automatic upd;
      repeat (80) @(posedge clk_sys);
   endtask : upd
   task automatic follow(input int a, k, input logic [31:0] amt, exp);
      p0 = slave_cmd_pos[a];
      step <= (k == 0) ? amt : 0;
      cmd_pos[0] <= cmd_pos[0] + ((k == 1) ? amt : 0);
      vector_distance <= vector_distance + ((k == 2) ? amt : 0);
      @(posedge clk_sys);
      step <= 0;
      upd();
      chk(slave_cmd_pos[a] - p0, exp);
   endtask : follow
   task automatic tracking;
      bus(1, 6'h09, 32'h0000_4E20);
      follow(1, 0, 100, 200);
      follow(1, 0, -50, -100);
      bus(1, 6'h08, 32'h0000_0008);
      follow(1, 1, 30, 60);
      bus(1, 6'h09, 32'hFFFF_EC78);
      follow(1, 1, 100, -50);
      bus(1, 6'h08, 32'h0000_0010);
      follow(1, 2, 40, -20);
      p0 = slave_cmd_pos[1];
      bus(1, 6'h0D, 32'h0000_0028);
      upd();
      chk(slave_cmd_pos[1] - p0, 40);
   endtask : tracking
   task automatic modes;
      bus(1, 6'h21, 32'h7FFF_FFFF);
      bus(0, 6'h21, 0);
      chk(rd, gear_pkg::RATIO_MAX);
      bus(1, 6'h21, 32'h8000_0000);
      bus(0, 6'h21, 0);
      chk(rd, 32'hFFEC_7801);
      bus(1, 6'h11, 32'h0000_2710);
      bus(1, 6'h12, 1);
      bus(1, 6'h14, 1);
      bus(0, 6'h14, 0);
      chk(rd[0], 1);
      bus(1, 6'h11, 0);
      bus(0, 6'h14, 0);
      chk(rd[0], 0);
      bus(1, 6'h11, 32'h0000_2710);
      bus(1, 6'h12, 0);
      bus(1, 6'h14, 1);
      bus(0, 6'h14, 0);
      chk(rd[0], 0);
      limit_switch[1] <= 1;
      upd();
      bus(0, 6'h0C, 0);
      chk(rd[0], 0);
      // jog on idle axis 5 reads back, and a stop drops it
      bus(1, 6'h2E, 32'h0000_0005);
      bus(0, 6'h2E, 0);
      chk(rd, 5);
      bus(1, 6'h2C, 1);
      bus(0, 6'h2E, 0);
      chk(rd, 0);
   endtask : modes
   task automatic ramp;
      bus(1, 6'h18, 32'h0000_0008);
      bus(1, 6'h1B, 32'h0000_0064);
      bus(1, 6'h19, 32'h0000_2710);
      // ratio climbs 0.2 per 20 counts of a 100-count span: steps 4, 8, 12, 16, then 20
      for (int k = 1; k <= 10; k++) follow(3, 1, 20, (k < 5) ? 4 * k : 20);
      follow(3, 1, 100, 100);
      bus(0, 6'h1F, 0);
      chk(rd, 40);
      bus(1, 6'h1C, 32'h0000_0002);
      bus(0, 6'h1F, 0);
      chk(rd, 0);
   endtask : ramp
   task automatic finish_test;
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      #3ms;
      fails++;
      finish_test();
   end
   initial begin
      {nrst, read, write, address, writedata, step} = '0;
      {cmd_pos, vector_distance, limit_switch} = '0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1;
      tracking();
      modes();
      ramp();
      finish_test();
   end
endmodule : tb_top
